//--- common/adrd_regs.svh
// Purpose: Address fields, encodings and reset values of the debug read decoder.
// Assumes: Included by the package and by every design file that decodes.
// Notes: Definitions only.
`ifndef ADRD_REGS_SVH
`define ADRD_REGS_SVH
`define ADRD_ADDR_W 36
`define ADRD_DATA_W 64
`define ADRD_ROW_HI 27
`define ADRD_ROW_LO 20
`define ADRD_RANGE_HI 19
`define ADRD_RANGE_LO 16
`define ADRD_ARRAY_HI 15
`define ADRD_ARRAY_LO 8
`define ADRD_COL_HI 4
`define ADRD_COL_LO 0
`define ADRD_SLOT_HI 7
`define ADRD_SLOT_LO 3
`define ADRD_SLICE_HI 2
`define ADRD_SLICE_LO 0
`define ADRD_CREG_BIT 0
`define ADRD_RANGE_ACCEL 4'h9
`define ADRD_ARR_A 8'h00
`define ADRD_ARR_B0 8'h02
`define ADRD_ARR_B1 8'h03
`define ADRD_ARR_C0 8'h04
`define ADRD_ARR_C1 8'h05
`define ADRD_ARR_XFER 8'h06
`define ADRD_ARR_CTRL 8'h08
`define ADRD_SLOT_LAST_ENTRY 5'h17
`define ADRD_SLOT_CONFIG 5'h18
`define ADRD_SLOT_OFFSET 5'h19
`define ADRD_SLOT_STATUS 5'h1a
`define ADRD_SLOT_OCCUPANCY 5'h1b
`define ADRD_SLICE_ZERO 3'h0
`define ADRD_CREG_SEL 1'h0
`define ADRD_CTRL_TC_BIT 13
`define ADRD_CTRL_ARB_BIT 12
`define ADRD_CTRL_TMO_HI 11
`define ADRD_CTRL_TMO_LO 0
`define ADRD_CTRL_TC_RST 1'h1
`define ADRD_CTRL_ARB_RST 1'h0
`define ADRD_CTRL_TMO_RST 12'hfff
`define ADRD_OCC_W 24
`endif

//--- common/adrd_pkg.sv
// Purpose: Shared types of the debug read decoder.
// Assumes: Field positions come from adrd_regs.svh.
// Notes: No logic here.
`include "adrd_regs.svh"
package adrd_pkg;
    // What an access targets, after decode.
    typedef enum logic [2:0] {
        ADRD_T_SHARED,
        ADRD_T_CTRL,
        ADRD_T_OCC,
        ADRD_T_UNDEF
    } adrd_target_type;

    // Decoded debug address.
    typedef struct packed {
        logic hit;
        adrd_target_type target;
        logic [7:0] array_select;
        logic [7:0] row;
        logic [4:0] column;
        logic [4:0] transfer_slot_select;
        logic [2:0] slice;
    } adrd_dec_type;

    // Select presented to the accelerator state read port.
    typedef struct packed {
        logic [7:0] array_select;
        logic [7:0] row;
        logic [4:0] column;
    } adrd_sel_type;

    // Writable control register fields.
    typedef struct packed {
        logic timeout_control;
        logic arbitration_policy;
        logic [11:0] timeout;
    } adrd_ctrl_type;

    typedef enum logic [1:0] {
        ADRD_IDLE,
        ADRD_ARB,
        ADRD_WAIT,
        ADRD_RESP
    } adrd_state_type;
endpackage : adrd_pkg

//--- verilog/adrd_addr_decode.sv
// Purpose: Splits a debug address into selects.
// Assumes: Reserved address bits are driven to zero by the host.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "adrd_regs.svh"
module adrd_addr_decode (
    input wire logic [`ADRD_ADDR_W-1:0] addr_in,
    output adrd_pkg::adrd_dec_type dec_out
);
    import adrd_pkg::*;

    // Field split, then target class from array and slot.
    always_comb begin
        dec_out.hit = (addr_in[`ADRD_RANGE_HI:`ADRD_RANGE_LO] == `ADRD_RANGE_ACCEL);
        dec_out.array_select = addr_in[`ADRD_ARRAY_HI:`ADRD_ARRAY_LO];
        dec_out.row = addr_in[`ADRD_ROW_HI:`ADRD_ROW_LO];
        dec_out.column = addr_in[`ADRD_COL_HI:`ADRD_COL_LO];
        dec_out.transfer_slot_select = addr_in[`ADRD_SLOT_HI:`ADRD_SLOT_LO];
        dec_out.slice = addr_in[`ADRD_SLICE_HI:`ADRD_SLICE_LO];
        unique case (dec_out.array_select)
            `ADRD_ARR_A, `ADRD_ARR_B0, `ADRD_ARR_B1, `ADRD_ARR_C0, `ADRD_ARR_C1: begin
                dec_out.target = ADRD_T_SHARED;
            end
            `ADRD_ARR_XFER: begin
                if (dec_out.transfer_slot_select == `ADRD_SLOT_OCCUPANCY) begin
                    dec_out.target = ADRD_T_OCC;
                end else if (dec_out.transfer_slot_select > `ADRD_SLOT_OCCUPANCY) begin
                    dec_out.target = ADRD_T_UNDEF;
                end else begin
                    dec_out.target = ADRD_T_SHARED;
                end
            end
            `ADRD_ARR_CTRL: begin
                dec_out.target = (addr_in[`ADRD_CREG_BIT] == `ADRD_CREG_SEL) ? ADRD_T_CTRL : ADRD_T_UNDEF;
            end
            default: begin
                dec_out.target = ADRD_T_UNDEF;
            end
        endcase
    end
endmodule : adrd_addr_decode
`default_nettype wire

//--- verilog/adrd_timeout.sv
// Purpose: Cycle counter that ends a stalled debug transaction.
// Assumes: run_in is high for every cycle the transaction waits.
// Notes: A limit of zero expires in the first waiting cycle.
`timescale 1ns/1ps
`default_nettype none
module adrd_timeout #(
    parameter int CNT_W = 12
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic enable_in,
    input wire logic [CNT_W-1:0] limit_in,
    output logic expire_out
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    // Count while waiting, restart whenever the wait ends.
    always_comb begin
        cnt_nxt = cnt_r;
        if (!run_in || expire_out) begin
            cnt_nxt = '0;
        end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Disabled timeouts never fire, however long the wait.
    assign expire_out = run_in && enable_in && (cnt_r >= limit_in);

    timeout_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !enable_in |-> !expire_out) else $error("Timeout fired while disabled.");
endmodule : adrd_timeout
`default_nettype wire

//--- verilog/adrd_debug_port.sv
// Purpose: Debug read decoder of the matrix accelerator: answers debug reads of
//          internal state and holds the debug port control register.
// Assumes: Host and accelerator logic share core_clk_in; one request at a time.
// Notes: Contract
// Contract
// - Internal state is readable; only the control register accepts writes.
// - Accesses target this block only when range bits 19:16 equal 1001.
// - Array 0 A, 2-3 B banks, 4-5 C banks, 6 transfer, 8 control.
// - Address bits 27:20 are a subspace-specific row.
// - Address bits 4:0 are an 8-byte column index.
// - Transfer slots 0 to 23 read the matching buffer entry; the select carries only slot bits 1:0, as column bits 4:3.
// - Slots 24 to 27 read configuration, offset, status and occupancy; slots 24 to 26 go out with the select of slots 0 to 2.
// - Transfer bits 2:0 pick a 64-bit slice of the 512-bit register.
// - Control subspace bit 0 selects the control register; higher bits reserved.
// - B bank reads return eight packed bytes in row-major order.
// - C bank reads fetch a 2048-bit row as packed 64-bit words.
// - Control bit 13 enables timeouts; resets to one.
// - Control bit 12 zero, its reset value, arbitrates with mission traffic.
// - Control bit 12 one accesses shared state at once.
// - Occupancy holds 24 thermometer valid flags, oldest at bit zero.
`timescale 1ns/1ps
`default_nettype none
`include "adrd_regs.svh"
module adrd_debug_port (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Debug host request.
    input wire logic dbg_req_in,
    input wire logic dbg_we_in,
    input wire logic [`ADRD_ADDR_W-1:0] dbg_addr_in,
    input wire logic [`ADRD_DATA_W-1:0] dbg_wdata_in,
    output logic dbg_ready_out,
    // Debug host answer.
    output logic dbg_rsp_valid_out,
    output logic dbg_rsp_err_out,
    output logic [`ADRD_DATA_W-1:0] dbg_rsp_data_out,
    // Accelerator internal state read port.
    output logic acc_rd_req_out,
    output adrd_pkg::adrd_sel_type acc_rd_sel_out,
    output logic acc_forced_access_out,
    input wire logic acc_rd_ack_in,
    input wire logic [`ADRD_DATA_W-1:0] acc_rd_data_in,
    input wire logic acc_mission_busy_in,
    input wire logic [`ADRD_OCC_W-1:0] acc_occupancy_in
);
    import adrd_pkg::*;

    adrd_dec_type dec;
    adrd_state_type state_r;
    adrd_state_type state_nxt;
    adrd_ctrl_type ctrl_r;
    adrd_ctrl_type ctrl_nxt;
    adrd_sel_type sel_r;
    adrd_sel_type sel_nxt;
    logic [`ADRD_DATA_W-1:0] data_r;
    logic [`ADRD_DATA_W-1:0] data_nxt;
    logic err_r;
    logic err_nxt;
    logic forced_r;
    logic forced_nxt;
    logic waiting;
    logic expire;
    logic take;
    logic [`ADRD_DATA_W-1:0] ctrl_word;
    logic [`ADRD_DATA_W-1:0] occ_word;

    adrd_addr_decode u_decode (
        .addr_in(dbg_addr_in),
        .dec_out(dec)
    );

    // Counts only while a shared-state access is outstanding.
    assign waiting = (state_r == ADRD_ARB) || (state_r == ADRD_WAIT);

    adrd_timeout #(
        .CNT_W(12)
    ) u_timeout (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .run_in(waiting),
        .enable_in(ctrl_r.timeout_control),
        .limit_in(ctrl_r.timeout),
        .expire_out(expire)
    );

    // A request is taken only when idle and addressed to this unit.
    assign dbg_ready_out = (state_r == ADRD_IDLE);
    assign take = dbg_req_in && dbg_ready_out && dec.hit;

    // Reserved control bits read as zero.
    always_comb begin
        ctrl_word = '0;
        ctrl_word[`ADRD_CTRL_TC_BIT] = ctrl_r.timeout_control;
        ctrl_word[`ADRD_CTRL_ARB_BIT] = ctrl_r.arbitration_policy;
        ctrl_word[`ADRD_CTRL_TMO_HI:`ADRD_CTRL_TMO_LO] = ctrl_r.timeout;
    end

    // Occupancy flags sit in the lowest slice; the rest of the 512 bits read zero.
    always_comb begin
        occ_word = '0;
        if (dec.slice == `ADRD_SLICE_ZERO) begin
            occ_word[`ADRD_OCC_W-1:0] = acc_occupancy_in;
        end
    end

    // Transaction sequencing, response data and the control register.
    always_comb begin
        state_nxt = state_r;
        ctrl_nxt = ctrl_r;
        sel_nxt = sel_r;
        data_nxt = data_r;
        err_nxt = err_r;
        forced_nxt = forced_r;
        unique case (state_r)
            ADRD_IDLE: begin
                if (take) begin
                    state_nxt = ADRD_RESP;
                    data_nxt = '0;
                    err_nxt = 1'b0;
                    if (dbg_we_in) begin
                        if (dec.target == ADRD_T_CTRL) begin
                            ctrl_nxt.timeout_control = dbg_wdata_in[`ADRD_CTRL_TC_BIT];
                            ctrl_nxt.arbitration_policy = dbg_wdata_in[`ADRD_CTRL_ARB_BIT];
                            ctrl_nxt.timeout = dbg_wdata_in[`ADRD_CTRL_TMO_HI:`ADRD_CTRL_TMO_LO];
                        end else begin
                            err_nxt = 1'b1;
                        end
                    end else begin
                        unique case (dec.target)
                            ADRD_T_CTRL: begin
                                data_nxt = ctrl_word;
                            end
                            ADRD_T_OCC: begin
                                data_nxt = occ_word;
                            end
                            ADRD_T_UNDEF: begin
                                data_nxt = '0;
                            end
                            ADRD_T_SHARED: begin
                                // Row and column go out untouched; the storage
                                // returns B as bytes and C as 2048-bit rows.
                                sel_nxt.array_select = dec.array_select;
                                sel_nxt.row = dec.row;
                                sel_nxt.column = dec.column;
                                forced_nxt = ctrl_r.arbitration_policy;
                                if (ctrl_r.arbitration_policy || !acc_mission_busy_in) begin
                                    state_nxt = ADRD_WAIT;
                                end else begin
                                    state_nxt = ADRD_ARB;
                                end
                            end
                            default: begin
                                data_nxt = '0;
                            end
                        endcase
                    end
                end
            end
            ADRD_ARB: begin
                // Wait for mission traffic to leave shared state.
                if (expire) begin
                    state_nxt = ADRD_RESP;
                    data_nxt = '0;
                    err_nxt = 1'b1;
                end else if (!acc_mission_busy_in) begin
                    state_nxt = ADRD_WAIT;
                end
            end
            ADRD_WAIT: begin
                if (acc_rd_ack_in) begin
                    state_nxt = ADRD_RESP;
                    data_nxt = acc_rd_data_in;
                end else if (expire) begin
                    state_nxt = ADRD_RESP;
                    data_nxt = '0;
                    err_nxt = 1'b1;
                end
            end
            ADRD_RESP: begin
                state_nxt = ADRD_IDLE;
                forced_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= ADRD_IDLE;
            ctrl_r.timeout_control <= `ADRD_CTRL_TC_RST;
            ctrl_r.arbitration_policy <= `ADRD_CTRL_ARB_RST;
            ctrl_r.timeout <= `ADRD_CTRL_TMO_RST;
            sel_r <= '0;
            data_r <= '0;
            err_r <= 1'b0;
            forced_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ctrl_r <= ctrl_nxt;
            sel_r <= sel_nxt;
            data_r <= data_nxt;
            err_r <= err_nxt;
            forced_r <= forced_nxt;
        end
    end

    // The answer is a one-cycle pulse; data and error come from flip-flops.
    assign dbg_rsp_valid_out = (state_r == ADRD_RESP);
    assign dbg_rsp_err_out = err_r;
    assign dbg_rsp_data_out = data_r;
    assign acc_rd_req_out = (state_r == ADRD_WAIT);
    assign acc_rd_sel_out = sel_r;
    assign acc_forced_access_out = forced_r && (state_r == ADRD_WAIT);

    one_answer_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        dbg_rsp_valid_out |=> !dbg_rsp_valid_out) else $error("Answer held longer than one cycle.");

    range_miss_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (dbg_req_in && dbg_ready_out && dbg_addr_in[`ADRD_RANGE_HI:`ADRD_RANGE_LO] != `ADRD_RANGE_ACCEL)
        |=> dbg_ready_out && !dbg_rsp_valid_out) else $error("Foreign range was taken.");

    write_reject_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (take && dbg_we_in && dec.target != ADRD_T_CTRL) |=> dbg_rsp_valid_out && dbg_rsp_err_out)
        else $error("State write not rejected.");

    ctrl_write_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (take && dbg_we_in && dec.target == ADRD_T_CTRL) |=> ##1
        ctrl_word == ($past(dbg_wdata_in, 2) & 64'h0000_0000_0000_3fff)) else $error("Control write lost.");

    arb_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (acc_rd_req_out && !acc_forced_access_out && $past(state_r) == ADRD_ARB)
        |-> $past(!acc_mission_busy_in)) else $error("Access issued during mission traffic.");

    forced_now_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (take && !dbg_we_in && dec.target == ADRD_T_SHARED && ctrl_r.arbitration_policy)
        |=> acc_rd_req_out && acc_forced_access_out) else $error("Forced access delayed.");

    timeout_err_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (expire && !(state_r == ADRD_WAIT && acc_rd_ack_in)) |=> dbg_rsp_valid_out && dbg_rsp_err_out)
        else $error("Timeout gave no error answer.");

    occ_read_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (take && !dbg_we_in && dec.target == ADRD_T_OCC && dec.slice == `ADRD_SLICE_ZERO)
        |=> dbg_rsp_data_out == {40'h0, $past(acc_occupancy_in)}) else $error("Occupancy misread.");

    ack_data_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (acc_rd_req_out && acc_rd_ack_in) |=> dbg_rsp_valid_out && !dbg_rsp_err_out
        && dbg_rsp_data_out == $past(acc_rd_data_in)) else $error("Read data not returned.");

    // The accelerator sees array, row and column exactly as addressed.
    sel_route_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (take && !dbg_we_in && dec.target == ADRD_T_SHARED)
        |=> acc_rd_sel_out == $past({dec.array_select, dec.row, dec.column}))
        else $error("Select not forwarded.");

    // A pending request keeps its select until it ends.
    sel_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (acc_rd_req_out && !acc_rd_ack_in && !expire) |=> acc_rd_req_out && $stable(acc_rd_sel_out))
        else $error("Pending select moved.");

    // A refused write must not touch the control register.
    reject_keep_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (take && dbg_we_in && dec.target != ADRD_T_CTRL) |=> $stable(ctrl_r))
        else $error("Refused write changed control.");

    // Reads of undefined targets answer zero without error, so a host can tell them from a refusal.
    undef_zero_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (take && !dbg_we_in && dec.target == ADRD_T_UNDEF)
        |=> dbg_rsp_valid_out && !dbg_rsp_err_out && dbg_rsp_data_out == '0)
        else $error("Undefined read not zero.");

    // Control reads return the register image.
    ctrl_read_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (take && !dbg_we_in && dec.target == ADRD_T_CTRL) |=> dbg_rsp_data_out == $past(ctrl_word))
        else $error("Control read wrong.");

    // Mission traffic holds the request back while arbitration is on.
    arb_block_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (state_r == ADRD_ARB && acc_mission_busy_in && !expire) |=> !acc_rd_req_out)
        else $error("Request issued while mission busy.");

    // The host may issue again right after the answer.
    ready_back_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        dbg_rsp_valid_out |=> dbg_ready_out)
        else $error("Ready not restored after answer.");

    // Only the lowest slice of the occupancy register carries flags.
    occ_high_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (take && !dbg_we_in && dec.target == ADRD_T_OCC && dec.slice != `ADRD_SLICE_ZERO)
        |=> dbg_rsp_data_out == '0) else $error("Upper occupancy slice not zero.");

    // Data that arrives with the expiry still wins; the late answer is no error.
    ack_wins_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (acc_rd_req_out && acc_rd_ack_in && expire) |=> !dbg_rsp_err_out)
        else $error("Late data answered as timeout.");

    // Forced requests only leave while the policy asks for them.
    forced_gate_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        acc_forced_access_out |-> acc_rd_req_out && ctrl_r.arbitration_policy)
        else $error("Forced access without policy.");
endmodule : adrd_debug_port
`default_nettype wire

//--- test/adrd_acc_model.sv
// Purpose: Accelerator state read port seen by the debug read decoder.
// Assumes: One outstanding request; sel_in stays stable while req_in is high.
// Notes: lat_in of 8'hff never answers, so the decoder's timeout can be reached.
`timescale 1ns/1ps
`default_nettype none
module adrd_acc_model (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic req_in,
    input wire adrd_pkg::adrd_sel_type sel_in,
    input wire logic [7:0] lat_in,
    output logic ack_out,
    output logic [63:0] data_out
);
    import adrd_pkg::*;
    logic [7:0] wait_r;
    logic [7:0] wait_nxt;
    logic [63:0] last_r;
    logic [63:0] last_nxt;
    logic [63:0] word;

    // The word encodes the select, so a wrong row or column shows in the data.
    // Between answers the bus carries the inverse of the last word, never a stale copy.
    always_comb begin
        word = {43'h2a5a5a5a5a5, sel_in};
        ack_out = req_in && (wait_r == lat_in) && (lat_in != 8'hff);
        data_out = ack_out ? word : ~last_r;
        wait_nxt = req_in ? wait_r + 8'h01 : 8'h00;
        last_nxt = ack_out ? word : last_r;
    end

    // Wait counter and last word.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_r <= 8'h00;
            last_r <= 64'h0;
        end else begin
            wait_r <= wait_nxt;
            last_r <= last_nxt;
        end
    end
endmodule : adrd_acc_model
`default_nettype wire

//--- test/accel_debug_read_decoder_tb.sv
// Purpose: Self-checking bench of the debug read decoder.
// Assumes: One request at a time; reserved address bits are zero.
// Notes: Accelerator answers come from adrd_acc_model.
`timescale 1ns/1ps
`default_nettype none
`include "adrd_regs.svh"
module accel_debug_read_decoder_tb;
    import adrd_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n, req, we, busy, ready, rsp_valid, rsp_err, acc_req, forced, ack, rerr;
    logic [35:0] addr;
    logic [63:0] wdata, rsp_data, acc_data, rdata;
    logic [23:0] occ;
    logic [7:0] lat;
    logic seen_forced = 1'b0;
    adrd_sel_type acc_sel;
    int error_cnt = 0;
    int n_compared = 0;
    int ncyc;
    logic [7:0] arrs[5] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05};
    logic [4:0] slots[5] = '{5'd0, 5'd23, 5'd24, 5'd25, 5'd26};
    localparam logic [35:0] CTRL = {8'h00, 8'h00, 4'h9, 8'h08, 8'h00};

    adrd_debug_port adrd_debug_port_i (.core_clk_in(core_clk), .rst_n_in(rst_n), .dbg_req_in(req),
        .dbg_we_in(we), .dbg_addr_in(addr), .dbg_wdata_in(wdata), .dbg_ready_out(ready),
        .dbg_rsp_valid_out(rsp_valid), .dbg_rsp_err_out(rsp_err), .dbg_rsp_data_out(rsp_data),
        .acc_rd_req_out(acc_req), .acc_rd_sel_out(acc_sel), .acc_forced_access_out(forced),
        .acc_rd_ack_in(ack), .acc_rd_data_in(acc_data), .acc_mission_busy_in(busy),
        .acc_occupancy_in(occ));
    adrd_acc_model adrd_acc_model_i (.core_clk_in(core_clk), .rst_n_in(rst_n), .req_in(acc_req),
        .sel_in(acc_sel), .lat_in(lat), .ack_out(ack), .data_out(acc_data));

    // Clock at 40 MHz.
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // Remember whether a forced request ever reached the accelerator port.
    always @(posedge core_clk) begin
        if (acc_req === 1'b1 && forced === 1'b1) seen_forced <= 1'b1;
    end

    function automatic logic [35:0] mk(input logic [7:0] arr, input logic [7:0] row, input logic [7:0] low);
        return {8'h00, row, 4'h9, arr, low};
    endfunction : mk

    function automatic logic [63:0] accw(input logic [7:0] arr, input logic [7:0] row, input logic [4:0] col);
        return {43'h2a5a5a5a5a5, arr, row, col};
    endfunction : accw

    function automatic logic [63:0] ctl(input logic tc, input logic arb, input logic [11:0] tmo);
        return {50'h0, tc, arb, tmo};
    endfunction : ctl

    task automatic chk64(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk64

    task automatic chk1(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // The request is taken at the second edge; the address is scrambled once released.
    task automatic start(input logic w, input logic [35:0] a, input logic [63:0] d);
        @(posedge core_clk);
        req <= 1'b1;
        we <= w;
        addr <= a;
        wdata <= d;
        #1;
        chk1("ready", 1'b1, ready);
        @(posedge core_clk);
        req <= 1'b0;
        we <= 1'b0;
        addr <= ~a;
    endtask : start

    // Waits for the answer pulse; ncyc is 1 when it follows the take edge directly.
    // Looking before the next edge matters, as a one-cycle answer is gone after it.
    task automatic wait_rsp;
        for (ncyc = 1; ncyc <= 64; ncyc++) begin
            #1;
            if (rsp_valid === 1'b1) break;
            @(posedge core_clk);
        end
        if (ncyc > 64) begin
            error_cnt++;
            $display("mismatch rsp_valid expected 1 seen none");
            tally_and_finish();
        end
        rdata = rsp_data;
        rerr = rsp_err;
        @(posedge core_clk);
        #1;
        chk1("single_rsp", 1'b0, rsp_valid);
    endtask : wait_rsp

    task automatic rd(input logic [35:0] a, input logic [63:0] ed, input logic ee, input string what);
        start(1'b0, a, 64'h0);
        wait_rsp();
        chk64(what, ed, rdata);
        chk1(what, ee, rerr);
    endtask : rd

    task automatic wr(input logic [35:0] a, input logic [63:0] d, input logic ee);
        start(1'b1, a, d);
        wait_rsp();
        chk1("wr_err", ee, rerr);
    endtask : wr

    // Main sequence: control register, subspaces, arbitration, timeout.
    initial begin
        rst_n = 1'b0;
        req = 1'b0;
        we = 1'b0;
        addr = 36'h0;
        wdata = 64'h0;
        busy = 1'b0;
        occ = 24'h00003f;
        lat = 8'h01;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(CTRL, ctl(1'b1, 1'b0, 12'hfff), 1'b0, "ctrl_rst");
        wr(CTRL, ctl(1'b1, 1'b0, 12'h004), 1'b0);
        rd(CTRL, ctl(1'b1, 1'b0, 12'h004), 1'b0, "ctrl_wr");
        wr(mk(8'h02, 8'h00, 8'h00), 64'hffff_ffff_ffff_ffff, 1'b1);
        rd(CTRL, ctl(1'b1, 1'b0, 12'h004), 1'b0, "ctrl_keep");
        $display("test control done");
        for (int i = 0; i < 5; i++) begin
            rd(mk(arrs[i], 8'(i * 61 + 7), {3'h0, 5'(i * 7 + 3)}), accw(arrs[i], 8'(i * 61 + 7), 5'(i * 7 + 3)), 1'b0, "array");
            rd(mk(8'h06, 8'(i + 1), {slots[i], 3'h5}), accw(8'h06, 8'(i + 1), {slots[i][1:0], 3'h5}), 1'b0, "xfer");
        end
        rd(mk(8'h06, 8'h00, {5'd27, 3'h0}), {40'h0, 24'h00003f}, 1'b0, "occ");
        rd(mk(8'h06, 8'h00, {5'd27, 3'h1}), 64'h0, 1'b0, "occ_hi");
        rd(mk(8'h08, 8'h00, 8'h01), 64'h0, 1'b0, "ctrl_sel1");
        $display("test subspaces done");
        start(1'b0, {8'h00, 8'h00, 4'h8, 8'h08, 8'h00}, 64'h0);
        repeat (6) begin
            @(posedge core_clk);
            #1;
            chk1("no_rsp", 1'b0, rsp_valid);
        end
        $display("test foreign range done");
        wr(CTRL, ctl(1'b0, 1'b0, 12'h004), 1'b0);
        @(posedge core_clk);
        busy <= 1'b1;
        start(1'b0, mk(8'h02, 8'h03, 8'h09), 64'h0);
        repeat (6) begin
            @(posedge core_clk);
            #1;
            chk1("acc_req_held", 1'b0, acc_req);
        end
        @(posedge core_clk);
        busy <= 1'b0;
        wait_rsp();
        chk64("arb_data", accw(8'h02, 8'h03, 5'h09), rdata);
        chk1("forced_idle", 1'b0, seen_forced);
        wr(CTRL, ctl(1'b1, 1'b1, 12'h004), 1'b0);
        @(posedge core_clk);
        busy <= 1'b1;
        rd(mk(8'h03, 8'h44, 8'h02), accw(8'h03, 8'h44, 5'h02), 1'b0, "forced");
        chk1("forced_seen", 1'b1, seen_forced);
        @(posedge core_clk);
        busy <= 1'b0;
        $display("test arbitration done");
        wr(CTRL, ctl(1'b1, 1'b0, 12'h004), 1'b0);
        @(posedge core_clk);
        lat <= 8'hff;
        rd(mk(8'h04, 8'h05, 8'h06), 64'h0, 1'b1, "tmo");
        chk1("tmo_cycles", 1'b1, ncyc == 6);
        @(posedge core_clk);
        lat <= 8'h03;
        rd(mk(8'h05, 8'h06, 8'h07), accw(8'h05, 8'h06, 5'h07), 1'b0, "slow");
        $display("test timeout done");
        tally_and_finish();
    end
endmodule : accel_debug_read_decoder_tb
`default_nettype wire
